/* File: common/tcc_pkg.sv */
// tcc_pkg: constants, field positions and types of the 16-bit capture/compare timer.
// assumes a simple synchronous register port driven by the local processor.
`default_nettype none
package tcc_pkg;

  // register byte addresses
  localparam logic [15:0] TCC_MODE_ADDR  = 16'hFF60;
  localparam logic [15:0] TCC_EDGE_ADDR  = 16'hFF61;
  localparam logic [15:0] TCC_CTRL_ADDR  = 16'hFF62;
  localparam logic [15:0] TCC_COUNT_ADDR = 16'hFF10;
  localparam logic [15:0] TCC_CCA_ADDR   = 16'hFF12;
  localparam logic [15:0] TCC_CCB_ADDR   = 16'hFF14;

  // timer_mode_reg fields
  localparam int TCC_RUN_HI_BIT  = 3;
  localparam int TCC_RUN_LO_BIT  = 2;
  localparam int TCC_OUT_SEL_BIT = 1;
  localparam int TCC_WRAP_BIT    = 0;
  // prescale_edge_reg fields
  localparam int TCC_IN_B_HI_BIT = 7;
  localparam int TCC_IN_B_LO_BIT = 6;
  localparam int TCC_IN_A_HI_BIT = 5;
  localparam int TCC_IN_A_LO_BIT = 4;
  // cc_ctrl_reg fields
  localparam int TCC_B_CAP_BIT   = 2;
  localparam int TCC_A_SRC_BIT   = 1;
  localparam int TCC_A_CAP_BIT   = 0;

  // reset values and counter landmarks
  localparam logic [7:0]  TCC_REG8_RST  = 8'h00;
  localparam logic [15:0] TCC_REG16_RST = 16'h0000;
  localparam logic [15:0] TCC_CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] TCC_CNT_ONE   = 16'h0001;

  // run modes held in run_mode_hi/lo
  typedef enum logic [1:0] {
    TCC_STOP  = 2'b00,
    TCC_FREE  = 2'b01,
    TCC_CLR_E = 2'b10,
    TCC_CLR_M = 2'b11
  } tcc_mode_t;

  // one register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } tcc_req_t;

  // valid-edge decode: 00 falling, 01 rising, 11 both, 10 none
  function automatic logic tcc_edge(input logic [1:0] sel, input logic rise, input logic fall);
    tcc_edge = (sel == 2'b00) ? fall :
               (sel == 2'b01) ? rise :
               (sel == 2'b11) ? (rise | fall) : 1'b0;
  endfunction : tcc_edge

endpackage : tcc_pkg
`default_nettype wire

/* File: src/tcc_timer.sv */
// tcc_timer: 16-bit up counter with two capture/compare registers, edge inputs and toggle output.
// assumes pins and register port are synchronous to core_clk_i; count clock equals core_clk_i.
`default_nettype none
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire tcc_req_t    req_i,
  input  wire logic        timer_in_a_i,
  input  wire logic        timer_in_b_i,
  output logic      [15:0] rd_data_o,
  output logic             rd_valid_o,
  output logic             match_irq_a_o,
  output logic             match_irq_b_o,
  output logic             timer_out_o
);

  // register state
  logic [7:0]  timer_mode_ff;
  logic [3:0]  edge_sel_ff;
  logic [2:0]  cc_ctrl_ff;
  logic [15:0] count_ff;
  logic [15:0] cc_a_ff;
  logic [15:0] cc_b_ff;
  logic        in_a_ff;
  logic        in_b_ff;
  logic        wrap_pend_ff;
  logic        cap_a_d_ff;
  logic        cap_b_d_ff;
  logic        irq_a_ff;
  logic        irq_b_ff;
  logic        tout_ff;
  logic [15:0] rd_data_ff;
  logic        rd_valid_ff;

  logic [15:0] nxt_count;
  logic [15:0] nxt_cc_a;
  logic [15:0] nxt_cc_b;
  logic [7:0]  nxt_timer_mode;
  logic        nxt_wrap_pend;
  logic        nxt_irq_a;
  logic        nxt_irq_b;
  logic        nxt_tout;
  logic [15:0] nxt_rd_data;

  // address decode
  wire logic wr_mode  = req_i.wr & (req_i.addr == TCC_MODE_ADDR);
  wire logic wr_edge  = req_i.wr & (req_i.addr == TCC_EDGE_ADDR);
  wire logic wr_ctrl  = req_i.wr & (req_i.addr == TCC_CTRL_ADDR);
  wire logic wr_cca   = req_i.wr & (req_i.addr == TCC_CCA_ADDR);
  wire logic wr_ccb   = req_i.wr & (req_i.addr == TCC_CCB_ADDR);

  // mode and selects
  wire tcc_mode_t run_mode = tcc_mode_t'({timer_mode_ff[TCC_RUN_HI_BIT], timer_mode_ff[TCC_RUN_LO_BIT]});
  wire logic running   = (run_mode != TCC_STOP);
  wire logic out_sel   = timer_mode_ff[TCC_OUT_SEL_BIT];
  wire logic a_cap     = cc_ctrl_ff[TCC_A_CAP_BIT];
  wire logic a_src     = cc_ctrl_ff[TCC_A_SRC_BIT];
  wire logic b_cap     = cc_ctrl_ff[TCC_B_CAP_BIT];
  // field positions inside the stored upper nibble of prescale_edge_reg
  wire logic [1:0] sel_a = edge_sel_ff[TCC_IN_A_HI_BIT-4:TCC_IN_A_LO_BIT-4];
  wire logic [1:0] sel_b = edge_sel_ff[TCC_IN_B_HI_BIT-4:TCC_IN_B_LO_BIT-4];

  // pin edge detection, gated off while stopped
  wire logic a_rise = timer_in_a_i & ~in_a_ff;
  wire logic a_fall = ~timer_in_a_i & in_a_ff;
  wire logic b_rise = timer_in_b_i & ~in_b_ff;
  wire logic b_fall = ~timer_in_b_i & in_b_ff;
  wire logic edge_a = running & tcc_edge(sel_a, a_rise, a_fall);
  wire logic edge_b = running & tcc_edge(sel_b, b_rise, b_fall);
  // reverse-phase edge of in_a used as a cc_reg_a trigger; both-edges gives none
  wire logic edge_a_rev = running & (sel_a != 2'b11) & tcc_edge(sel_a, a_fall, a_rise);

  // capture events, only in capture mode
  wire logic cap_a = a_cap & (a_src ? edge_a_rev : edge_b);
  wire logic cap_b = b_cap & edge_a;

  // compare matches; a zero compare value fires only on the step after a wrap
  wire logic eq_a    = (count_ff == cc_a_ff);
  wire logic eq_b    = (count_ff == cc_b_ff);
  wire logic zero_ok = (count_ff != TCC_REG16_RST) | wrap_pend_ff;
  wire logic match_a = running & ~a_cap & eq_a & zero_ok;
  wire logic match_b = running & ~b_cap & eq_b & zero_ok;
  wire logic rolls   = running & (count_ff == TCC_CNT_MAX);
  wire logic clr_m   = (run_mode == TCC_CLR_M) & match_a;
  wire logic clr_e   = (run_mode == TCC_CLR_E) & edge_a;
  wire logic wrap_ev = rolls & (cc_a_ff == TCC_CNT_MAX);

  // counter next value
  always_comb begin
    if (!running) begin
      nxt_count = TCC_REG16_RST;
    end else if (clr_m || clr_e) begin
      nxt_count = TCC_REG16_RST;
    end else begin
      nxt_count = count_ff + TCC_CNT_ONE;
    end
  end

  // wrap pending marks the zero cycle after any pass from FFFFH, cleared or rolled
  assign nxt_wrap_pend = rolls;

  // mode register: software writes, hardware set of wrap_flag wins
  always_comb begin
    nxt_timer_mode = timer_mode_ff;
    if (wr_mode) begin
      nxt_timer_mode = {4'h0, req_i.wdata[3:0]};
    end
    if (wrap_ev || (wrap_pend_ff && timer_mode_ff[TCC_WRAP_BIT])) begin
      nxt_timer_mode[TCC_WRAP_BIT] = 1'b1;
    end
  end

  // capture registers: capture beats a write in the same cycle
  assign nxt_cc_a = cap_a ? count_ff : (wr_cca ? req_i.wdata : cc_a_ff);
  assign nxt_cc_b = cap_b ? count_ff : (wr_ccb ? req_i.wdata : cc_b_ff);

  // interrupt pulses: compare fires on match, capture one cycle after the capture
  assign nxt_irq_a = a_cap ? (cap_a_d_ff & running) : match_a;
  assign nxt_irq_b = b_cap ? (cap_b_d_ff & running) : match_b;

  // output toggle on either match, optionally on in_a edge
  assign nxt_tout = tout_ff ^ (running & (match_a | match_b | (out_sel & edge_a)));

  // read mux; count comes from the stable flop so no count is lost
  always_comb begin
    nxt_rd_data = TCC_REG16_RST;
    case (req_i.addr)
      TCC_MODE_ADDR:  nxt_rd_data = {8'h00, timer_mode_ff};
      TCC_EDGE_ADDR:  nxt_rd_data = {8'h00, edge_sel_ff, 4'h0};
      TCC_CTRL_ADDR:  nxt_rd_data = {13'h0000, cc_ctrl_ff};
      TCC_COUNT_ADDR: nxt_rd_data = count_ff;
      TCC_CCA_ADDR:   nxt_rd_data = cap_a ? count_ff : cc_a_ff;
      TCC_CCB_ADDR:   nxt_rd_data = cap_b ? count_ff : cc_b_ff;
      default:        nxt_rd_data = TCC_REG16_RST;
    endcase
  end

  // configuration registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_mode_ff <= TCC_REG8_RST;
      edge_sel_ff   <= 4'h0;
      cc_ctrl_ff    <= 3'h0;
    end else begin
      timer_mode_ff <= nxt_timer_mode;
      if (wr_edge) edge_sel_ff <= req_i.wdata[7:4];
      if (wr_ctrl) cc_ctrl_ff <= req_i.wdata[2:0];
    end
  end

  // counter and capture/compare registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_ff     <= TCC_REG16_RST;
      cc_a_ff      <= TCC_REG16_RST;
      cc_b_ff      <= TCC_REG16_RST;
      wrap_pend_ff <= 1'b0;
    end else begin
      count_ff     <= nxt_count;
      cc_a_ff      <= nxt_cc_a;
      cc_b_ff      <= nxt_cc_b;
      wrap_pend_ff <= nxt_wrap_pend;
    end
  end

  // pin history, capture delay, interrupts and output
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_a_ff    <= 1'b0;
      in_b_ff    <= 1'b0;
      cap_a_d_ff <= 1'b0;
      cap_b_d_ff <= 1'b0;
      irq_a_ff   <= 1'b0;
      irq_b_ff   <= 1'b0;
      tout_ff    <= 1'b0;
    end else begin
      in_a_ff    <= timer_in_a_i;
      in_b_ff    <= timer_in_b_i;
      cap_a_d_ff <= cap_a;
      cap_b_d_ff <= cap_b;
      irq_a_ff   <= nxt_irq_a;
      irq_b_ff   <= nxt_irq_b;
      tout_ff    <= nxt_tout;
    end
  end

  // read answer, one cycle after the request
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_ff  <= TCC_REG16_RST;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= req_i.rd ? nxt_rd_data : rd_data_ff;
      rd_valid_ff <= req_i.rd;
    end
  end

  assign rd_data_o     = rd_data_ff;
  assign rd_valid_o    = rd_valid_ff;
  assign match_irq_a_o = irq_a_ff;
  assign match_irq_b_o = irq_b_ff;
  assign timer_out_o   = tout_ff;

  // checks on the timer behaviour
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_stop_zero_count: assert property (!running |=> count_ff == 16'h0000)
    else $error("count not zero while stopped");

  a_free_run_step: assert property (run_mode == TCC_FREE && $stable(run_mode) ##0 !clr_e
                                    |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("free-running count did not step by one");

  a_clear_on_match: assert property (run_mode == TCC_CLR_M && match_a |=> count_ff == 16'h0000)
    else $error("count not cleared on match a");

  a_clear_on_edge: assert property (run_mode == TCC_CLR_E && edge_a |=> count_ff == 16'h0000)
    else $error("count not cleared on in_a edge");

  a_match_irq_b: assert property (running && !b_cap && eq_b && zero_ok |=> match_irq_b_o)
    else $error("compare b match gave no interrupt");

  a_cap_irq_delay: assert property (cap_a && running ##1 running |=> match_irq_a_o)
    else $error("capture a interrupt not one cycle after capture");

  a_cap_b_value: assert property (cap_b |=> cc_b_ff == $past(count_ff))
    else $error("cc_reg_b did not capture count");

  a_compare_hold: assert property (!a_cap && !wr_cca |=> $stable(cc_a_ff))
    else $error("compare register a changed without a write");

  a_wrap_set: assert property (wrap_ev |=> timer_mode_ff[0])
    else $error("wrap_flag not set on rollover");

  a_wrap_clear_lost: assert property (wrap_pend_ff && timer_mode_ff[0] |=> timer_mode_ff[0])
    else $error("wrap_flag cleared before count left zero");

  a_irq_pulse: assert property (match_irq_a_o |=> !match_irq_a_o || $past(count_ff) == $past(count_ff, 2))
    else $error("match_irq_a held longer than one cycle");

  a_stopped_quiet: assert property (!running && $past(!running) |=> !match_irq_a_o && !match_irq_b_o)
    else $error("interrupt while stopped");

  // timer_out moves only on a match or a selected in_a edge while running
  a_tout_stopped: assert property (!running |=> $stable(timer_out_o))
    else $error("timer_out changed while stopped");

  a_tout_on_match: assert property (running && (match_a || match_b) |=> timer_out_o != $past(timer_out_o))
    else $error("timer_out did not toggle on a match");

  a_tout_on_edge: assert property (running && out_sel && edge_a |=> timer_out_o != $past(timer_out_o))
    else $error("timer_out did not toggle on the in_a edge");

  a_tout_quiet: assert property (!match_a && !match_b && !(out_sel && edge_a) |=> $stable(timer_out_o))
    else $error("timer_out toggled without a cause");

  // compare interrupts and capture/compare register contents
  a_match_irq_a: assert property (match_a |=> match_irq_a_o)
    else $error("compare a match gave no interrupt");

  a_compare_miss: assert property (running && !a_cap && !eq_a |=> !match_irq_a_o)
    else $error("compare a interrupt without a match");

  a_cap_a_value: assert property (cap_a |=> cc_a_ff == $past(count_ff))
    else $error("cc_reg_a did not capture count");

  a_cap_b_hold: assert property (!b_cap && !wr_ccb |=> $stable(cc_b_ff))
    else $error("compare register b changed without a write");

  a_ccb_write: assert property (wr_ccb && !cap_b |=> cc_b_ff == $past(req_i.wdata))
    else $error("cc_reg_b did not take the written word");

  a_cap_wins_b: assert property (cap_b && wr_ccb |=> cc_b_ff == $past(count_ff))
    else $error("write beat a capture into cc_reg_b");

  a_read_capture: assert property (req_i.rd && req_i.addr == TCC_CCA_ADDR && cap_a
                                   |=> rd_data_o == $past(count_ff))
    else $error("read of cc_reg_a missed a coincident capture");

  // zero compare value, rollover and wrap_flag
  a_zero_no_match: assert property (count_ff == 16'h0000 && !wrap_pend_ff |-> !match_a && !match_b)
    else $error("zero count matched without a rollover");

  a_wrap_pending: assert property (rolls |=> count_ff == 16'h0000 && wrap_pend_ff)
    else $error("rollover did not mark the zero cycle");

  a_zero_wrap_irq: assert property (running && !b_cap && cc_b_ff == 16'h0000 && wrap_pend_ff
                                    |=> match_irq_b_o)
    else $error("zero compare b gave no interrupt after a rollover");

  a_wrap_any_mode: assert property (rolls && cc_a_ff == 16'hFFFF |=> timer_mode_ff[TCC_WRAP_BIT])
    else $error("wrap_flag missed a rollover with cc_reg_a at its top");

  // register read-back
  a_edge_fields: assert property (req_i.rd && req_i.addr == TCC_EDGE_ADDR
                                  |=> rd_data_o == {8'h00, $past(edge_sel_ff), 4'h0})
    else $error("edge select fields read back out of place");

  a_ctrl_fields: assert property (req_i.rd && req_i.addr == TCC_CTRL_ADDR
                                  |=> rd_data_o == {13'h0000, $past(cc_ctrl_ff)})
    else $error("capture control fields read back out of place");

  a_count_read: assert property (req_i.rd && req_i.addr == TCC_COUNT_ADDR
                                 |=> rd_data_o == $past(count_ff))
    else $error("count read back a stale value");

  // pin edges and interrupt pulses
  a_stop_no_edge: assert property (!running |-> !edge_a && !edge_b && !cap_a && !cap_b)
    else $error("pin edge seen while stopped");

  a_cap_irq_b: assert property (cap_b && running ##1 running |=> match_irq_b_o)
    else $error("capture b interrupt not one cycle after capture");

  a_irq_b_pulse: assert property (match_irq_b_o |=> !match_irq_b_o)
    else $error("match_irq_b held longer than one cycle");

  c_free_wrap:   cover property (run_mode == TCC_FREE && rolls);
  c_cap_a_pin_b: cover property (cap_a && !a_src);
  c_clear_match: cover property (clr_m ##1 match_irq_a_o);
  c_tout_edge:   cover property (out_sel && edge_a && running);
  c_clear_edge:  cover property (clr_e ##1 count_ff == 16'h0000);

endmodule : tcc_timer
`default_nettype wire

/* File: test/tcc_pin_src.sv */
// tcc_pin_src: model of the pulse sources on the two timer input pins.
// assumes its caller runs on the core clock; pins idle low.
`default_nettype none
module tcc_pin_src (
  input  wire logic clk_i,
  output logic      in_a_o,
  output logic      in_b_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // both pins idle low from time zero
  initial begin
    in_a_o = 1'b0;
    in_b_o = 1'b0;
  end

  // in_b rises, in_a follows gap cycles later; each held wid cycles, wid no fewer than gap
  task automatic pair(input int wid, input int gap);
    @(posedge clk_i);
    in_b_o <= 1'b1;
    repeat (gap) @(posedge clk_i);
    in_a_o <= 1'b1;
    repeat (wid - gap) @(posedge clk_i);
    in_b_o <= 1'b0;
    repeat (gap) @(posedge clk_i);
    in_a_o <= 1'b0;
  endtask : pair
endmodule : tcc_pin_src
`default_nettype wire

/* File: test/tcc_timer_tb.sv */
// tcc_timer_tb: self-checking bench for the capture/compare timer.
// assumes the core clock at 20 MHz also serves as the count clock.
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin fail_count++; \
  $display("FAIL %s exp %0h got %0h", nm, e, s); end end
module tcc_timer_tb
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct { string nm; logic [15:0] ex; bit rel; } tcc_note_t;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        in_a, in_b, rd_valid, irq_a, irq_b, t_out, t_out_q;
  tcc_req_t    req;
  logic [15:0] rd_data, last_rd, ex;
  int          fail_count, samples_checked, n_a, n_b, n_t;
  tcc_note_t   notes[$];
  tcc_note_t   nt;

  always #25 core_clk = ~core_clk;

  tcc_timer u_dut (.core_clk_i(core_clk), .reset_n_i(reset_n), .req_i(req), .timer_in_a_i(in_a),
    .timer_in_b_i(in_b), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .match_irq_a_o(irq_a),
    .match_irq_b_o(irq_b), .timer_out_o(t_out));
  tcc_pin_src u_pins (.clk_i(core_clk), .in_a_o(in_a), .in_b_o(in_b));

  // counts interrupt pulses and output toggles, checks each named read against the oldest note
  always @(posedge core_clk) begin
    if (irq_a === 1'b1) n_a <= n_a + 1;
    if (irq_b === 1'b1) n_b <= n_b + 1;
    t_out_q <= t_out;
    if (t_out !== t_out_q) n_t <= n_t + 1;
    if (rd_valid === 1'b1) begin
      if (notes.size() == 0) `CHK("stray read", 1'b0, 1'b1)
      else begin
        nt = notes.pop_front();
        ex = nt.rel ? last_rd + nt.ex : nt.ex;
        if (nt.nm != "") `CHK(nt.nm, ex, rd_data)
        last_rd = rd_data;
      end
    end
  end

  task automatic go(input int n);
    repeat (n) @(posedge core_clk);
  endtask : go

  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    req <= '0;
  endtask : wr

  // one-cycle read strobe; the expectation is noted first
  task automatic rd(input logic [15:0] a, input string nm, input logic [15:0] e, input bit rel = 1'b0);
    notes.push_back('{nm, e, rel});
    @(posedge core_clk);
    req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge core_clk);
    req <= '0;
  endtask : rd

  task automatic results();
    if (notes.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // run-length limit
  initial begin
    go(99000);
    fail_count++;
    results();
  end

  initial begin
    int          a0, b0, t0;
    logic [1:0]  s;
    logic [15:0] v;
    req = '0;
    void'($urandom(32'h8A34));
    go(2);
    reset_n <= 1'b1;
    // reset values, field layout, unmapped place, pins ignored while stopped
    rd(TCC_MODE_ADDR, "mode reset", 16'h0000);
    rd(TCC_CCB_ADDR, "cc b reset", 16'h0000);
    rd(16'hFF00, "unmapped", 16'h0000);
    wr(TCC_EDGE_ADDR, 16'h00F3);
    wr(TCC_CTRL_ADDR, 16'h0005);
    rd(TCC_EDGE_ADDR, "edge fields", 16'h00F0);
    a0 = n_a;
    b0 = n_b;
    u_pins.pair(6, 3);
    go(4);
    `CHK("stopped irqs", 0, n_a + n_b - a0 - b0)
    rd(TCC_COUNT_ADDR, "stopped count", 16'h0000);
    // capture on the falling, rising and both-edges choices; in_a lags in_b by 3 counts
    for (int k = 0; k < 3; k++) begin
      s = (k == 2) ? 2'b11 : 2'(k);
      wr(TCC_MODE_ADDR, 16'h0000);
      wr(TCC_EDGE_ADDR, {8'h00, s, s, 4'h0});
      wr(TCC_CTRL_ADDR, 16'h0005);
      wr(TCC_MODE_ADDR, 16'h0006);
      a0 = n_a;
      b0 = n_b;
      t0 = n_t;
      u_pins.pair(6, 3);
      go(4);
      `CHK("capture irq a", (s == 2'b11) ? 2 : 1, n_a - a0)
      `CHK("capture irq b", (s == 2'b11) ? 2 : 1, n_b - b0)
      `CHK("edge toggles", (s == 2'b11) ? 2 : 1, n_t - t0)
      rd(TCC_CCA_ADDR, "", 16'h0000);
      rd(TCC_CCB_ADDR, "capture gap", 16'h0003, 1'b1);
    end
    // clear on in_a rise, reverse-phase capture of the in_a fall into cc_reg_a
    wr(TCC_MODE_ADDR, 16'h0000);
    wr(TCC_EDGE_ADDR, 16'h0010);
    wr(TCC_CTRL_ADDR, 16'h0003);
    wr(TCC_CCB_ADDR, 16'hFFFF);
    a0 = n_a;
    b0 = n_b;
    t0 = n_t;
    wr(TCC_MODE_ADDR, 16'h000A);
    u_pins.pair(6, 3);
    go(4);
    `CHK("edge clear irq a", 1, n_a - a0)
    `CHK("edge clear irq b", 0, n_b - b0)
    `CHK("edge clear toggles", 1, n_t - t0)
    rd(TCC_CCA_ADDR, "count after edge clear", 16'h0005);
    // compare on cc_reg_b at a random value, in_a pulsed meanwhile
    wr(TCC_MODE_ADDR, 16'h0000);
    wr(TCC_CTRL_ADDR, 16'h0000);
    v = 16'($urandom_range(40, 4));
    wr(TCC_CCB_ADDR, v);
    wr(TCC_CCA_ADDR, 16'hFFFF);
    b0 = n_b;
    t0 = n_t;
    wr(TCC_MODE_ADDR, 16'h0004);
    u_pins.pair(6, 3);
    for (int i = 0; i < 60 && n_b == b0; i++) go(1);
    go(3);
    `CHK("match b pulses", 1, n_b - b0)
    `CHK("match toggles", 1, n_t - t0)
    rd(TCC_CCB_ADDR, "cc b kept", v);
    // clear and restart on cc_reg_a match, period of 5 counts
    wr(TCC_MODE_ADDR, 16'h0000);
    wr(TCC_CCA_ADDR, 16'h0004);
    wr(TCC_CCB_ADDR, 16'h0002);
    a0 = n_a;
    b0 = n_b;
    wr(TCC_MODE_ADDR, 16'h000C);
    go(50);
    `CHK("clear period a", 1'b1, (n_a - a0) inside {[9:11]})
    `CHK("clear period b", 1'b1, (n_b - b0) inside {[9:11]})
    // full wrap: zero compare, overflow flag and a clear that comes too early
    wr(TCC_MODE_ADDR, 16'h0000);
    wr(TCC_CCA_ADDR, 16'hFFFF);
    wr(TCC_CCB_ADDR, 16'h0000);
    a0 = n_a;
    b0 = n_b;
    t0 = n_t;
    wr(TCC_MODE_ADDR, 16'h0004);
    go(65535);
    wr(TCC_MODE_ADDR, 16'h0004);
    rd(TCC_MODE_ADDR, "wrap flag", 16'h0005);
    go(3);
    `CHK("zero compare", 1, n_b - b0)
    `CHK("ffff compare", 1, n_a - a0)
    `CHK("wrap toggles", 2, n_t - t0)
    go(4);
    results();
  end
endmodule : tcc_timer_tb
`default_nettype wire
